// File: sptd_map.svh
// Constants for the speed threshold detector: defaults, sentinels, codes.
// Assumes speeds in whole r/min and percentages in whole percent.
`ifndef SPTD_MAP_SVH
`define SPTD_MAP_SVH

// ****************************************
// Setting defaults and ranges
// ****************************************
`define SPTD_SENS_DEFAULT    7'h0a
`define SPTD_SENS_MAX        7'h64
`define SPTD_PRIMARY_DEFAULT 14'h012c
`define SPTD_SECOND_DEFAULT  14'h02ee
`define SPTD_THIRD_DEFAULT   14'h0708
`define SPTD_SPEED_MAX       14'h0e10
`define SPTD_REVERSE_SAME    14'h270f

// ****************************************
// Output terminal function codes
// ****************************************
`define SPTD_FN_UP_TO_SPEED  8'h01
`define SPTD_FN_CMD_ONE      8'h02
`define SPTD_FN_CMD_TWO      8'h03
`define SPTD_FN_CMD_THREE    8'h04
`define SPTD_FN_FB_ONE       8'h05
`define SPTD_FN_FB_TWO       8'h06
`define SPTD_FN_FB_THREE     8'h07
`define SPTD_TERMINALS       4
`define SPTD_TERM_DO2        2

`endif

// File: sptd_pkg.sv
// Types shared by the speed threshold detector files.
// Assumes sptd_map.svh is on the include path.
package sptd_pkg;
	// Control mode of the drive
	typedef enum logic [1:0] {
		sptd_mode_speed,
		sptd_mode_vf,
		sptd_mode_torque,
		sptd_mode_position
	} sptd_mode_t;
endpackage

// File: sptd_compare.sv
// Three threshold comparators for one speed source.
// Assumes a signed speed and already-chosen first threshold.
`timescale 1ns/1ns
`default_nettype none
module sptd_compare (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               enable,     // Source may detect
	input  wire logic               force_off,  // Alarm, stop or reset
	input  wire logic               start,      // Start command
	input  wire logic signed [14:0] speed,      // Signed r/min
	input  wire logic        [13:0] thr_one,    // Direction-chosen
	input  wire logic        [13:0] thr_two,
	input  wire logic        [13:0] thr_three,
	output logic             [2:0]  detect      // Registered flags
);
	logic [13:0] mag;        // Magnitude of speed
	logic [13:0] thr [3];    // Threshold per flag
	assign mag = speed[14] ? 14'((-speed)) : speed[13:0];
	assign thr[0] = thr_one;
	assign thr[1] = thr_two;
	assign thr[2] = thr_three;

	// ****************************************
	// One registered comparator per flag
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_cmp
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					detect[i] <= 1'b0;
				end else if (force_off || !enable) begin
					detect[i] <= 1'b0;
				end else if (thr[i] == 14'h0000) begin
					detect[i] <= start;
				end else begin
					// At or above threshold
					detect[i] <= (mag >= thr[i]);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: sptd_top.sv
// Speed threshold detector: up-to-speed flag, three command-based and
// three feedback-based detection flags, and output terminal routing.
// Assumes all inputs are synchronous to clock and settings stay in range.
// Speeds are signed r/min; a negative value means reverse rotation.
// Thresholds and sensitivity are held steady by the setting logic.
`timescale 1ns/1ns
`default_nettype none
`include "sptd_map.svh"
module sptd_top
	import sptd_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire sptd_mode_t         control_mode,
	input  wire logic               encoder_vector,   // Vector with encoder
	input  wire logic               start_command,
	input  wire logic               drive_alarm,
	input  wire logic               output_stop_input,
	input  wire logic               reset_input,
	input  wire logic signed [14:0] setpoint_speed,   // Running setpoint
	input  wire logic signed [14:0] ramped_command,   // After accel/decel
	input  wire logic signed [14:0] encoder_speed,    // Measured speed
	input  wire logic signed [14:0] vf_speed,         // From out frequency
	input  wire logic        [6:0]  up_to_speed_sensitivity,
	input  wire logic        [13:0] primary_detect_threshold,
	input  wire logic        [13:0] reverse_detect_threshold,
	input  wire logic        [13:0] second_detect_threshold,
	input  wire logic        [13:0] third_detect_threshold,
	input  wire logic               load_defaults,    // Factory reset
	input  wire logic        [1:0]  select_index,     // Terminal to set
	input  wire logic        [7:0]  select_code,      // Function code
	input  wire logic               select_write,     // Write strobe
	output logic                    up_to_speed_flag,
	output logic                    command_speed_detect_one,
	output logic                    command_speed_detect_two,
	output logic                    command_speed_detect_three,
	output logic                    feedback_speed_detect_one,
	output logic                    feedback_speed_detect_two,
	output logic                    feedback_speed_detect_three,
	output logic             [3:0]  terminal_out      // 0..2 DO1..3, 3 relay
);
	// Timing in brief: every flag is one register stage behind the inputs
	// that decide it, and the terminal mux adds no further stage, so a
	// terminal shows a new flag value in the same cycle as the flag port.
	// Settings are levels; a change takes effect at the next edge.

	// ****************************************
	// Speed selection
	// ****************************************
	logic               vf;          // Constant V/F mode
	logic               force_off;   // Common shutdown term
	logic signed [14:0] cmd_speed;   // Speed for command flags
	logic signed [14:0] fb_speed;    // Speed for feedback flags
	logic signed [14:0] test_speed;  // Speed for up-to-speed
	logic               cmd_enable;  // Command flags may detect
	logic [13:0]        rev_thr;     // Reverse threshold after sentinel
	logic [13:0]        cmd_thr_one; // First threshold, command side
	logic [13:0]        fb_thr_one;  // First threshold, feedback side
	logic [2:0]         cmd_det;     // Command flag vector
	logic [2:0]         fb_det;      // Feedback flag vector
	logic [7:0]         term_fn [`SPTD_TERMINALS]; // Routing codes

	// Mode decode
	assign vf = (control_mode == sptd_mode_vf);
	// Shutdown inputs are not registered here; the flags fall one edge
	// after any of them rises, and stay low while it is held
	assign force_off = drive_alarm | output_stop_input | reset_input;
	// V/F makes both sources the same converted speed
	assign cmd_speed = vf ? vf_speed : ramped_command;
	assign fb_speed = vf ? vf_speed : encoder_speed;
	// Encoder vector tests feedback; otherwise ramped command
	assign test_speed = vf ? vf_speed :
		(encoder_vector ? encoder_speed : ramped_command);
	// Torque and position have no meaningful speed command
	assign cmd_enable = (control_mode == sptd_mode_speed) || vf;

	// ****************************************
	// First-threshold direction choice
	// ****************************************
	// Continuous terms, so a change of a setting alone, with the speed
	// standing still, still reaches the comparators
	// Sentinel reuses the primary setting
	assign rev_thr = (reverse_detect_threshold == `SPTD_REVERSE_SAME) ?
		primary_detect_threshold : reverse_detect_threshold;
	// Sign bit is the direction; zero speed counts as forward
	assign cmd_thr_one = cmd_speed[14] ? rev_thr : primary_detect_threshold;
	assign fb_thr_one = fb_speed[14] ? rev_thr : primary_detect_threshold;

	// ****************************************
	// Comparator banks
	// ****************************************
	// Two identical banks keep the command and feedback paths apart, so a
	// mode that silences one side cannot disturb the other
	sptd_compare u_cmd (
		.clock     (clock),
		.rst       (rst),
		.enable    (cmd_enable),
		.force_off (force_off),
		.start     (start_command),
		.speed     (cmd_speed),
		.thr_one   (cmd_thr_one),
		.thr_two   (second_detect_threshold),
		.thr_three (third_detect_threshold),
		.detect    (cmd_det)
	);
	// Feedback flags work in every control mode
	sptd_compare u_fb (
		.clock     (clock),
		.rst       (rst),
		.enable    (1'b1),
		.force_off (force_off),
		.start     (start_command),
		.speed     (fb_speed),
		.thr_one   (fb_thr_one),
		.thr_two   (second_detect_threshold),
		.thr_three (third_detect_threshold),
		.detect    (fb_det)
	);

	// ****************************************
	// Flag outputs
	// ****************************************
	// Plain renames of the registered vectors
	assign command_speed_detect_one    = cmd_det[0];
	assign command_speed_detect_two    = cmd_det[1];
	assign command_speed_detect_three  = cmd_det[2];
	assign feedback_speed_detect_one   = fb_det[0];
	assign feedback_speed_detect_two   = fb_det[1];
	assign feedback_speed_detect_three = fb_det[2];

	// ****************************************
	// Up-to-speed band
	// ****************************************
	// Band is setpoint * pct / 100; a wide product avoids overflow
	// The division truncates, so a small setpoint at a low sensitivity
	// gives a zero band and only an exact match raises the flag
	logic [6:0]  sens;     // Clamped sensitivity
	logic [13:0] set_mag;  // Setpoint magnitude
	logic [20:0] band;     // Allowed deviation in r/min
	logic [14:0] diff;     // Absolute deviation
	// Settings above full scale act as full scale
	assign sens = (up_to_speed_sensitivity > `SPTD_SENS_MAX) ?
		`SPTD_SENS_MAX : up_to_speed_sensitivity;
	assign set_mag = setpoint_speed[14] ?
		14'((-setpoint_speed)) : setpoint_speed[13:0];
	// Product is exact; only the final division rounds down
	assign band = 21'((21'(set_mag) * 21'(sens)) / 21'd100);
	// Signed difference, so a reversed test speed counts as far off;
	// speeds stay within the setting range, so it never wraps
	assign diff = (test_speed >= setpoint_speed) ?
		15'(test_speed - setpoint_speed) : 15'(setpoint_speed - test_speed);

	// Flag within band; forced off by shutdown or no start
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// Low until the drive has run
			up_to_speed_flag <= 1'b0;
		end else if (force_off || !start_command) begin
			// Nothing to be up to speed with
			up_to_speed_flag <= 1'b0;
		end else begin
			// Deviation compared at full width
			up_to_speed_flag <= (21'(diff) <= band);
		end
	end

	// ****************************************
	// Output terminal function selection
	// ****************************************
	// Defaults put up-to-speed on the second output
	// Factory reset wins over a write in the same cycle, so a default
	// load never leaves one terminal with a stray code
	genvar t;
	generate
		for (t = 0; t < `SPTD_TERMINALS; t++) begin : g_term
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					term_fn[t] <= (t == `SPTD_TERM_DO2 - 1) ?
						`SPTD_FN_UP_TO_SPEED : 8'h00;
				end else if (load_defaults) begin
					term_fn[t] <= (t == `SPTD_TERM_DO2 - 1) ?
						`SPTD_FN_UP_TO_SPEED : 8'h00;
				end else if (select_write && select_index == 2'(t)) begin
					// Write lands at the next edge
					term_fn[t] <= select_code;
				end
			end
			// Terminal drive follows its code; unknown codes stay off
			// Combinational so the terminal needs no extra cycle
			always_comb begin
				case (term_fn[t])
					`SPTD_FN_UP_TO_SPEED: terminal_out[t] = up_to_speed_flag;
					`SPTD_FN_CMD_ONE:     terminal_out[t] = cmd_det[0];
					`SPTD_FN_CMD_TWO:     terminal_out[t] = cmd_det[1];
					`SPTD_FN_CMD_THREE:   terminal_out[t] = cmd_det[2];
					`SPTD_FN_FB_ONE:      terminal_out[t] = fb_det[0];
					`SPTD_FN_FB_TWO:      terminal_out[t] = fb_det[1];
					`SPTD_FN_FB_THREE:    terminal_out[t] = fb_det[2];
					default:              terminal_out[t] = 1'b0;
				endcase
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: sptd_equip.sv
// Model of the equipment wired to the output terminals.
// Assumes terminal_out is settled by each rising edge of clock.
`timescale 1ns/1ns
`default_nettype none
module sptd_equip (
	input  wire logic       clock,
	input  wire logic [3:0] terminal_out, // DO1..DO3, relay
	output logic      [3:0] seen          // Latched terminal states
);
	// Relays and inputs act on the level, one cycle late
	always_ff @(posedge clock) begin
		seen <= terminal_out;
	end
endmodule
`default_nettype wire

// File: sptd_top_sva.sv
// Checker for the speed threshold detector flags.
// Assumes it is bound to sptd_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "sptd_map.svh"
module sptd_top_sva
	import sptd_pkg::*;
(
	input wire logic               clock,
	input wire logic               rst,
	input wire sptd_mode_t         control_mode,
	input wire logic               encoder_vector,
	input wire logic               start_command,
	input wire logic               drive_alarm,
	input wire logic               output_stop_input,
	input wire logic               reset_input,
	input wire logic signed [14:0] setpoint_speed,
	input wire logic signed [14:0] ramped_command,
	input wire logic signed [14:0] encoder_speed,
	input wire logic        [13:0] primary_detect_threshold,
	input wire logic        [13:0] reverse_detect_threshold,
	input wire logic        [13:0] second_detect_threshold,
	input wire logic               up_to_speed_flag,
	input wire logic               command_speed_detect_one,
	input wire logic               command_speed_detect_two,
	input wire logic               feedback_speed_detect_two
);
	// ****************************************
	// Helper terms
	// ****************************************
	logic stop; // Any forcing input
	logic go;   // Running in speed control with nothing forcing
	assign stop = drive_alarm | output_stop_input | reset_input;
	assign go = start_command & ~stop & (control_mode == sptd_mode_speed);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ****************************************
	// Flag relations, one cycle after their cause
	// ****************************************
	property p_force; stop |=> !(up_to_speed_flag | command_speed_detect_one
		| feedback_speed_detect_two); endproperty
	a_force: assert property (p_force) else $error("flag not forced off");
	property p_mode; control_mode inside {sptd_mode_torque, sptd_mode_position}
		|=> !command_speed_detect_one && !command_speed_detect_two; endproperty
	a_mode: assert property (p_mode) else $error("command flag in torque");
	property p_fwd; go && ramped_command >= 0 |=> command_speed_detect_one ==
		(int'($past(ramped_command)) >= int'($past(primary_detect_threshold)));
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward flag one wrong");
	property p_rev; go && ramped_command < 0 && reverse_detect_threshold !=
		`SPTD_REVERSE_SAME |=> command_speed_detect_one == (-int'($past(
		ramped_command)) >= int'($past(reverse_detect_threshold))); endproperty
	a_rev: assert property (p_rev) else $error("reverse flag one wrong");
	property p_same; go && ramped_command < 0 && reverse_detect_threshold ==
		`SPTD_REVERSE_SAME |=> command_speed_detect_one == (-int'($past(
		ramped_command)) >= int'($past(primary_detect_threshold))); endproperty
	a_same: assert property (p_same) else $error("sentinel not primary");
	property p_two; go && ramped_command >= 0 |=> command_speed_detect_two ==
		(int'($past(ramped_command)) >= int'($past(second_detect_threshold)));
	endproperty
	a_two: assert property (p_two) else $error("command flag two wrong");
	property p_fb; go && encoder_speed >= 0 |=> feedback_speed_detect_two ==
		(int'($past(encoder_speed)) >= int'($past(second_detect_threshold)));
	endproperty
	a_fb: assert property (p_fb) else $error("feedback flag two wrong");
	property p_band; go && !encoder_vector && setpoint_speed == ramped_command
		|=> up_to_speed_flag; endproperty
	a_band: assert property (p_band) else $error("up-to-speed missing");
	property p_enc; go && encoder_vector && setpoint_speed == encoder_speed
		|=> up_to_speed_flag; endproperty
	a_enc: assert property (p_enc) else $error("encoder up-to-speed");
endmodule
bind sptd_top sptd_top_sva u_sva (.clock, .rst, .control_mode,
	.encoder_vector, .start_command, .drive_alarm, .output_stop_input,
	.reset_input, .setpoint_speed, .ramped_command, .encoder_speed,
	.primary_detect_threshold, .reverse_detect_threshold,
	.second_detect_threshold, .up_to_speed_flag, .command_speed_detect_one,
	.command_speed_detect_two, .feedback_speed_detect_two);
`default_nettype wire

// File: speed_threshold_detector_test.sv
// Self-checking bench for the speed threshold detector.
// Assumes sptd_top with its package and the equipment model.
`timescale 1ns/1ns
`default_nettype none
`include "sptd_map.svh"
module speed_threshold_detector_test;
	import sptd_pkg::*;
	logic clock = 0, rst = 1, encoder_vector = 0, start_command = 0;
	logic drive_alarm = 0, output_stop_input = 0, reset_input = 0;
	logic load_defaults = 0, select_write = 0;
	logic up_to_speed_flag, command_speed_detect_one, command_speed_detect_two;
	logic command_speed_detect_three, feedback_speed_detect_one;
	logic feedback_speed_detect_two, feedback_speed_detect_three;
	sptd_mode_t control_mode = sptd_mode_speed;
	logic signed [14:0] setpoint_speed = 0, ramped_command = 0;
	logic signed [14:0] encoder_speed = 0, vf_speed = 0;
	logic [6:0] up_to_speed_sensitivity = `SPTD_SENS_DEFAULT;
	logic [13:0] primary_detect_threshold = `SPTD_PRIMARY_DEFAULT;
	logic [13:0] reverse_detect_threshold = `SPTD_REVERSE_SAME;
	logic [13:0] second_detect_threshold = `SPTD_SECOND_DEFAULT;
	logic [13:0] third_detect_threshold = `SPTD_THIRD_DEFAULT;
	logic [1:0] select_index = 2'h0;
	logic [7:0] select_code = 8'h00;
	logic [3:0] terminal_out, seen;
	int n_errors = 0, checked = 0, cycles = 0;
	logic signed [14:0] sp [6] = '{15'h012b, 15'h012c, 15'h02ed, 15'h02ee,
		15'h0707, 15'h0708}; // Each threshold and one below it
	always #50 clock = ~clock; // 10 MHz
	sptd_top DUT (.clock, .rst, .control_mode, .encoder_vector,
		.start_command, .drive_alarm, .output_stop_input, .reset_input,
		.setpoint_speed, .ramped_command, .encoder_speed, .vf_speed,
		.up_to_speed_sensitivity, .primary_detect_threshold,
		.reverse_detect_threshold, .second_detect_threshold,
		.third_detect_threshold, .load_defaults, .select_index, .select_code,
		.select_write, .up_to_speed_flag, .command_speed_detect_one,
		.command_speed_detect_two, .command_speed_detect_three,
		.feedback_speed_detect_one, .feedback_speed_detect_two,
		.feedback_speed_detect_three, .terminal_out);
	sptd_equip u_equip (.clock, .terminal_out, .seen);
	// ****************************************
	// Shared tasks
	// ****************************************
	task tick; @(posedge clock); #10; endtask // Drive and look off the edge
	task chk(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task drv(input logic signed [14:0] r, input logic signed [14:0] e);
		ramped_command = r;
		encoder_speed = e;
		tick;
	endtask
	task complete_run;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_up; // Band is 100 around a 1000 setpoint
		chk(terminal_out[1], 1'b0);
		start_command = 1;
		setpoint_speed = 15'h03e8;
		drv(15'h03e8, 0); chk(terminal_out[1], 1'b1);
		drv(15'h044c, 0); chk(up_to_speed_flag, 1'b1);
		drv(15'h044d, 0); chk(up_to_speed_flag, 1'b0);
		up_to_speed_sensitivity = 7'h7f; // Above full scale, acts as 100
		drv(15'h07d0, 0); chk(up_to_speed_flag, 1'b1);
		drv(15'h07d1, 0); chk(up_to_speed_flag, 1'b0);
		up_to_speed_sensitivity = `SPTD_SENS_DEFAULT;
		encoder_vector = 1;
		drv(0, 15'h03e8); chk(up_to_speed_flag, 1'b1);
		encoder_vector = 0;
	endtask
	task t_thr; // Edges of all three thresholds on the command side; feedback checked at the third only
		for (int i = 0; i < 6; i++) begin
			drv(sp[i], sp[i]);
			chk(command_speed_detect_one, i > 0);
			chk(command_speed_detect_two, i > 2);
			chk(command_speed_detect_three, i > 4);
			chk(feedback_speed_detect_three, i > 4);
		end
	endtask
	task t_rev; // Sentinel reuse, then a distinct reverse threshold
		drv(-15'sh012b, 0); chk(command_speed_detect_one, 1'b0);
		drv(-15'sh012c, 0); chk(command_speed_detect_one, 1'b1);
		reverse_detect_threshold = 14'h01f4;
		drv(-15'sh012c, 0); chk(command_speed_detect_one, 1'b0);
		drv(-15'sh01f4, 0); chk(command_speed_detect_one, 1'b1);
		reverse_detect_threshold = `SPTD_REVERSE_SAME;
	endtask
	task t_mode; // Torque blocks command flags; V/F shares one speed
		control_mode = sptd_mode_torque;
		drv(15'h07d0, 15'h07d0); chk(command_speed_detect_one, 1'b0);
		chk(feedback_speed_detect_one, 1'b1);
		control_mode = sptd_mode_position;
		drv(15'h07d0, 15'h07d0); chk(command_speed_detect_one, 1'b0);
		control_mode = sptd_mode_vf;
		vf_speed = 15'h0320;
		drv(0, 0); chk(command_speed_detect_two, 1'b1);
		chk(feedback_speed_detect_two, 1'b1);
		control_mode = sptd_mode_speed;
		setpoint_speed = 15'h07d0;
		drv(0, 0); chk(command_speed_detect_one, 1'b0);
	endtask
	task t_force; // Each forcing input alone, then recovery
		for (int k = 0; k < 3; k++) begin
			{drive_alarm, output_stop_input, reset_input} = 3'h4 >> k;
			drv(15'h0708, 15'h0708); chk(command_speed_detect_three, 1'b0);
			chk(feedback_speed_detect_three, 1'b0);
			{drive_alarm, output_stop_input, reset_input} = 3'h0;
			tick; chk(feedback_speed_detect_three, 1'b1);
		end
	endtask
	task t_zero; // Zero threshold follows the start command
		primary_detect_threshold = 14'h0000;
		start_command = 0;
		drv(0, 0); chk(command_speed_detect_one, 1'b0);
		start_command = 1;
		tick; chk(command_speed_detect_one, 1'b1);
		primary_detect_threshold = `SPTD_PRIMARY_DEFAULT;
	endtask
	task t_route; // Codes onto terminals, then factory defaults
		select_code = `SPTD_FN_UP_TO_SPEED;
		select_write = 1;
		tick; select_write = 0;
		setpoint_speed = 15'h03e8;
		drv(15'h03e8, 0); chk(terminal_out[0], 1'b1);
		drv(15'h0708, 0);
		select_index = 2'h3;
		for (int c = 2; c < 9; c++) begin
			select_code = 8'(c);
			select_write = 1;
			tick; select_write = 0;
			chk(terminal_out[3], c < 5);
			tick; chk(seen[3], c < 5);
		end
		select_index = 2'h1; // Take up-to-speed off its default terminal
		select_code = 8'h00;
		select_write = 1;
		tick; select_index = 2'h2;
		select_code = `SPTD_FN_FB_ONE;
		tick; select_write = 0;
		drv(15'h03e8, 15'h0190);
		chk(terminal_out[0], 1'b1);
		chk(terminal_out[1], 1'b0);
		chk(terminal_out[2], 1'b1);
		load_defaults = 1;
		tick; load_defaults = 0;
		tick; chk(terminal_out[0], 1'b0);
		chk(terminal_out[1], 1'b1);
		chk(terminal_out[2], 1'b0);
	endtask
	// Cuts a hang short well past the expected run of about 60 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			complete_run;
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		#10 rst = 0;
		t_up;
		t_thr;
		t_rev;
		t_mode;
		t_force;
		t_zero;
		t_route;
		complete_run;
	end
endmodule
`default_nettype wire
